// *** hdl/zcor_output_regs.sv ***
/*
  Output-side register bank of a two-zone conveyor controller, written
  cyclically by the line controller through a simple write/read port.
  Assumes zone logic on the same clock reports discharges and arrivals.
*/
`timescale 1ns/10ps
`default_nettype none

module zcor_output_regs #(
  parameter int unsigned ARRIVAL_WAIT_CYCLES = 1000
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wr_en,
  input wire logic [zcor_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [zcor_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [zcor_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [zcor_pkg::DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic [15:0] i_configured_left_speed,
  input wire logic [15:0] i_configured_right_speed,
  input wire logic i_gear_drive,
  input wire logic [1:0] i_zone_discharged,
  input wire logic [1:0] i_arrival_seen,
  output logic [1:0] o_release_pulse,
  output logic [1:0] o_accumulate,
  output logic [1:0] o_accum_upstream,
  output logic [1:0] o_arrival_confirm,
  output logic [1:0] o_jog_fwd,
  output logic [1:0] o_jog_rev,
  output logic [1:0] o_wake,
  output logic [1:0] o_maintenance,
  output logic [1:0] o_upstream_busy,
  output logic [1:0] o_indicator_flash_green,
  output logic [1:0] o_motor_enable,
  output logic [1:0] o_jam,
  output logic [1:0][15:0] o_live_word1,
  output logic [1:0][15:0] o_live_word2,
  output logic [1:0][15:0] o_release_echo,
  output logic [15:0] o_left_speed_ref,
  output logic [15:0] o_right_speed_ref,
  output logic o_speed_unit_rpm_x10,
  output logic o_induct_accept_tracking,
  output logic o_downstream_hold,
  output logic o_downstream_release_ok
);
  import zcor_pkg::*;

  localparam int unsigned CNT_W = $clog2(ARRIVAL_WAIT_CYCLES + 1);
  localparam logic [CNT_W-1:0] JAM_LIMIT = CNT_W'(ARRIVAL_WAIT_CYCLES - 1);

  if (ARRIVAL_WAIT_CYCLES < 2) begin : g_bad_wait
    $error("ARRIVAL_WAIT_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  // k: 0 accum control, 1 release, 2 hold word 1, 3 hold word 2
  function automatic logic [7:0] zone_addr(input int z, input int k);
    logic [7:0] a;
    a = 8'h00;
    case (k)
      0: a = (z == 0) ? OFF_UP_ACCUM : OFF_DN_ACCUM;
      1: a = (z == 0) ? OFF_UP_RELEASE : OFF_DN_RELEASE;
      2: a = (z == 0) ? OFF_UP_HOLD1 : OFF_DN_HOLD1;
      3: a = (z == 0) ? OFF_UP_HOLD2 : OFF_DN_HOLD2;
      default: a = 8'h00;
    endcase
    return a;
  endfunction

  function automatic logic wr_hit(input logic [7:0] a);
    return i_wr_en && (i_wr_addr == a);
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] accum [2];
  logic [15:0] rel [2];
  logic [15:0] rel_prev [2];
  logic [15:0] hold1 [2];
  logic [15:0] hold2 [2];
  logic [15:0] live1 [2];
  logic [15:0] live2 [2];
  logic [15:0] spd [2];
  logic [15:0] spd_last [2];
  logic [1:0] spd_seen;
  logic [15:0] induct;
  logic [15:0] discharge;
  logic [CNT_W-1:0] wait_cnt [2];
  zcor_arrival_t arr_state [2];
  wire logic [15:0] spd_ref [2];
  wire logic [15:0] spd_cfg [2];
  wire logic [1:0] commit;
  wire logic [1:0] both_zero;
  wire logic [1:0] both_ones;
  wire logic [1:0] jog;

  assign spd_cfg[0] = i_configured_left_speed;
  assign spd_cfg[1] = i_configured_right_speed;

  // ----------------------------------------------------------------
  // per-zone registers and tracking commit
  // ----------------------------------------------------------------
  for (genvar z = 0; z < 2; z++) begin : g_zone
    wire logic accum_on = accum[z][BIT_ACCUM];
    wire logic confirmed = i_arrival_seen[z] || o_arrival_confirm[z];
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        accum[z] <= REG_RESET;
        rel[z] <= REG_RESET;
        rel_prev[z] <= REG_RESET;
        hold1[z] <= REG_RESET;
        hold2[z] <= REG_RESET;
      end else begin
        if (wr_hit(zone_addr(z, 0))) begin
          accum[z] <= i_wr_data & ACCUM_USED_MASK;
        end
        if (wr_hit(zone_addr(z, 1))) begin
          rel[z] <= i_wr_data;
        end
        if (wr_hit(zone_addr(z, 2))) begin
          hold1[z] <= i_wr_data;
        end
        if (wr_hit(zone_addr(z, 3))) begin
          hold2[z] <= i_wr_data;
        end
        rel_prev[z] <= rel[z];
      end
    end
    assign o_release_pulse[z] = accum_on && (rel[z] != rel_prev[z]);
    assign commit[z] = o_release_pulse[z] || i_zone_discharged[z];
    assign both_zero[z] = (hold1[z] == TRACK_KEEP) && (hold2[z] == TRACK_KEEP);
    assign both_ones[z] = (hold1[z] == TRACK_CLEAR) &&
                          (hold2[z] == TRACK_CLEAR);
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        live1[z] <= REG_RESET;
        live2[z] <= REG_RESET;
      end else if (commit[z] && !both_zero[z]) begin
        live1[z] <= both_ones[z] ? REG_RESET : hold1[z];
        live2[z] <= both_ones[z] ? REG_RESET : hold2[z];
      end
    end
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        arr_state[z] <= ARR_IDLE;
        wait_cnt[z] <= '0;
      end else if (commit[z]) begin
        // a new carton outranks a late confirmation of the last one
        arr_state[z] <= ARR_WAIT;
        wait_cnt[z] <= '0;
      end else begin
        case (arr_state[z])
          ARR_IDLE: wait_cnt[z] <= '0;
          ARR_WAIT: begin
            if (confirmed) begin
              arr_state[z] <= ARR_IDLE;
            end else if (wait_cnt[z] == JAM_LIMIT) begin
              arr_state[z] <= ARR_JAM;
            end else begin
              wait_cnt[z] <= wait_cnt[z] + 1'b1;
            end
          end
          ARR_JAM: begin
            if (confirmed) begin
              arr_state[z] <= ARR_IDLE;
            end
          end
          default: arr_state[z] <= ARR_IDLE;
        endcase
      end
    end
    assign jog[z] = accum[z][BIT_JOG_FWD] || accum[z][BIT_JOG_REV];
    assign o_jog_fwd[z] = accum[z][BIT_JOG_FWD];
    assign o_jog_rev[z] = accum[z][BIT_JOG_REV];
    // accumulation, held by discharge status on downstream
    assign o_accumulate[z] = !jog[z] &&
      (accum_on || (z == 1 && discharge == STAT_HOLD));
    assign o_accum_upstream[z] = accum[z][BIT_ACCUM_UPSTREAM];
    assign o_arrival_confirm[z] = accum[z][BIT_ARRIVAL_CONFIRM];
    assign o_wake[z] = accum[z][BIT_WAKE] ||
      (z == 0 && induct == STAT_RUN_ACCEPT);
    assign o_maintenance[z] = accum[z][BIT_MAINT];
    assign o_upstream_busy[z] = accum[z][BIT_MAINT];
    assign o_indicator_flash_green[z] = accum[z][BIT_MAINT];
    assign o_motor_enable[z] = !accum[z][BIT_MAINT];
    assign o_jam[z] = (arr_state[z] == ARR_JAM);
    assign o_live_word1[z] = live1[z];
    assign o_live_word2[z] = live2[z];
    assign o_release_echo[z] = rel[z];
    chk_hold_copy: assert property (@(posedge i_clk)
      disable iff (i_reset) commit[z] && !both_zero[z] && !both_ones[z] |=>
      live1[z] == $past(hold1[z]) && live2[z] == $past(hold2[z]))
      else $error("holding words not copied at release");
    chk_zero_keeps: assert property (@(posedge i_clk)
      disable iff (i_reset) commit[z] && both_zero[z] |=>
      $stable(live1[z]) && $stable(live2[z]))
      else $error("zero holding words changed live tracking");
    chk_ffff_clears: assert property (@(posedge i_clk)
      disable iff (i_reset) commit[z] && both_ones[z] |=>
      live1[z] == 16'h0000 && live2[z] == 16'h0000)
      else $error("tracking not cleared");
    // sampled strobe and address, not the function's current-value view
    chk_release_change: assert property (@(posedge i_clk)
      disable iff (i_reset) i_wr_en && i_wr_addr == zone_addr(z, 1) &&
      i_wr_data != rel[z] && accum_on |=>
      o_release_pulse[z] ##1 (!o_release_pulse[z] || $past(i_wr_en)))
      else $error("release change gave no single pulse");
    chk_jam_timeout: assert property (@(posedge i_clk)
      disable iff (i_reset) $rose(o_jam[z]) |->
      $past(wait_cnt[z]) == JAM_LIMIT && !$past(confirmed))
      else $error("jam raised off the arrival timeout");
    chk_maint_stops: assert property (@(posedge i_clk)
      disable iff (i_reset) o_maintenance[z] |->
      !o_motor_enable[z] && o_upstream_busy[z] && o_indicator_flash_green[z])
      else $error("maintenance left motor enabled");
    chk_jog_override: assert property (@(posedge i_clk)
      disable iff (i_reset) jog[z] |-> !o_accumulate[z])
      else $error("accumulation active during jog");
    cov_release: cover property (@(posedge i_clk) disable iff (i_reset)
      o_release_pulse[z] ##1 !o_release_pulse[z]);
    cov_clear: cover property (@(posedge i_clk) disable iff (i_reset)
      commit[z] && both_ones[z]);
    cov_jam: cover property (@(posedge i_clk) disable iff (i_reset)
      $rose(o_jam[z]));
  end

  // ----------------------------------------------------------------
  // speed references
  // ----------------------------------------------------------------
  for (genvar s = 0; s < 2; s++) begin : g_speed
    wire logic [7:0] spd_off = (s == 0) ? OFF_LEFT_SPEED : OFF_RIGHT_SPEED;
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        spd[s] <= REG_RESET;
        spd_last[s] <= REG_RESET;
        spd_seen[s] <= 1'b0;
      end else begin
        if (wr_hit(spd_off)) begin
          spd[s] <= i_wr_data;
        end
        if (spd[s] != 16'h0000) begin
          spd_last[s] <= spd[s];
          spd_seen[s] <= 1'b1;
        end
      end
    end
    assign spd_ref[s] = (spd[s] != 16'h0000) ? spd[s] :
                        (spd_seen[s] ? spd_last[s] : spd_cfg[s]);
    chk_speed_zero: assert property (@(posedge i_clk)
      disable iff (i_reset) $past(spd[s]) != 16'h0000 &&
      spd[s] == 16'h0000 |-> spd_ref[s] == $past(spd[s]))
      else $error("zero speed dropped last reference");
    cov_speed_fall: cover property (@(posedge i_clk) disable iff (i_reset)
      $past(spd[s]) != 16'h0000 && spd[s] == 16'h0000);
  end

  assign o_left_speed_ref = spd_ref[0];
  assign o_right_speed_ref = spd_ref[1];
  assign o_speed_unit_rpm_x10 = i_gear_drive;

  // ----------------------------------------------------------------
  // induct and discharge status
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      induct <= REG_RESET;
      discharge <= REG_RESET;
    end else begin
      if (wr_hit(OFF_UP_INDUCT)) begin
        induct <= i_wr_data;
      end
      if (wr_hit(OFF_DN_DISCHARGE)) begin
        discharge <= i_wr_data;
      end
    end
  end

  assign o_induct_accept_tracking = (induct == STAT_ACCEPT_TRACK);
  assign o_downstream_hold = (discharge == STAT_HOLD);
  assign o_downstream_release_ok = (discharge == STAT_RELEASE_OK);

  chk_induct_wake: assert property (@(posedge i_clk)
    disable iff (i_reset) induct == STAT_RUN_ACCEPT |-> o_wake[0])
    else $error("induct status 4 did not wake upstream");
  chk_discharge_hold: assert property (@(posedge i_clk)
    disable iff (i_reset) discharge == STAT_HOLD && !jog[1] |->
    o_accumulate[1] && !o_downstream_release_ok)
    else $error("discharge status 5 did not hold");
  cov_induct: cover property (@(posedge i_clk) disable iff (i_reset)
    induct == STAT_RUN_ACCEPT ##1 induct == STAT_ACCEPT_TRACK);

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (i_rd_addr)
      OFF_LEFT_SPEED: rd_mux = spd[0];
      OFF_RIGHT_SPEED: rd_mux = spd[1];
      OFF_UP_ACCUM: rd_mux = accum[0];
      OFF_UP_RELEASE: rd_mux = rel[0];
      OFF_UP_HOLD1: rd_mux = hold1[0];
      OFF_UP_HOLD2: rd_mux = hold2[0];
      OFF_UP_INDUCT: rd_mux = induct;
      OFF_DN_ACCUM: rd_mux = accum[1];
      OFF_DN_RELEASE: rd_mux = rel[1];
      OFF_DN_HOLD1: rd_mux = hold1[1];
      OFF_DN_HOLD2: rd_mux = hold2[1];
      OFF_DN_DISCHARGE: rd_mux = discharge;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_mux;
      end
    end
  end

endmodule

`default_nettype wire

// *** hdl/zcor_pkg.sv ***
/*
  Shared constants for the zone control output register bank: register
  offsets, control bit positions, status codes, special tracking values.
  Assumes one system clock and a synchronous active-high reset.
*/
package zcor_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_LEFT_SPEED = 8'h28;
  localparam logic [7:0] OFF_RIGHT_SPEED = 8'h40;
  localparam logic [7:0] OFF_UP_ACCUM = 8'h68;
  localparam logic [7:0] OFF_UP_RELEASE = 8'h69;
  localparam logic [7:0] OFF_UP_HOLD1 = 8'h84;
  localparam logic [7:0] OFF_UP_HOLD2 = 8'h85;
  localparam logic [7:0] OFF_UP_INDUCT = 8'h86;
  localparam logic [7:0] OFF_DN_ACCUM = 8'hb8;
  localparam logic [7:0] OFF_DN_RELEASE = 8'hb9;
  localparam logic [7:0] OFF_DN_HOLD1 = 8'hd4;
  localparam logic [7:0] OFF_DN_HOLD2 = 8'hd5;
  localparam logic [7:0] OFF_DN_DISCHARGE = 8'he8;

  // ----------------------------------------------------------------
  // accumulation control bits
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ACCUM = 0;
  localparam int unsigned BIT_ACCUM_UPSTREAM = 8;
  localparam int unsigned BIT_ARRIVAL_CONFIRM = 9;
  localparam int unsigned BIT_JOG_FWD = 10;
  localparam int unsigned BIT_JOG_REV = 11;
  localparam int unsigned BIT_WAKE = 12;
  localparam int unsigned BIT_MAINT = 13;
  localparam logic [15:0] ACCUM_USED_MASK = 16'h3f01;

  // ----------------------------------------------------------------
  // status codes, tracking special values, reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] STAT_RUN_ACCEPT = 16'h0004;
  localparam logic [15:0] STAT_ACCEPT_TRACK = 16'h0001;
  localparam logic [15:0] STAT_HOLD = 16'h0005;
  localparam logic [15:0] STAT_RELEASE_OK = 16'h0001;
  localparam logic [15:0] TRACK_KEEP = 16'h0000;
  localparam logic [15:0] TRACK_CLEAR = 16'hffff;
  localparam logic [15:0] REG_RESET = 16'h0000;

  typedef enum logic [1:0] {ARR_IDLE, ARR_WAIT, ARR_JAM} zcor_arrival_t;

endpackage

// *** verif/zcor_plc_model.sv ***
/*
  Behavioural line controller for the zone output register bank: single
  register writes and reads, and a rewrite of the whole output image.
  Assumes the bank takes a request at the rising edge where its strobe
  is high and raises read-valid one cycle after a read is taken.
*/
`timescale 1ns/10ps
`default_nettype none

module zcor_plc_model (
  input wire logic i_clk,
  output logic o_wr_en,
  output logic [zcor_pkg::ADDR_W-1:0] o_wr_addr,
  output logic [zcor_pkg::DATA_W-1:0] o_wr_data,
  output logic o_rd_en,
  output logic [zcor_pkg::ADDR_W-1:0] o_rd_addr,
  input wire logic [zcor_pkg::DATA_W-1:0] i_rd_data,
  input wire logic i_rd_valid
);
  import zcor_pkg::*;

  localparam logic [7:0] IMG [12] = '{OFF_LEFT_SPEED, OFF_RIGHT_SPEED,
    OFF_UP_ACCUM, OFF_UP_RELEASE, OFF_UP_HOLD1, OFF_UP_HOLD2, OFF_UP_INDUCT,
    OFF_DN_ACCUM, OFF_DN_RELEASE, OFF_DN_HOLD1, OFF_DN_HOLD2,
    OFF_DN_DISCHARGE};

  initial begin
    o_wr_en = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 16'h0000;
    o_rd_en = 1'b0;
    o_rd_addr = 8'h00;
  end

  // ----------------------------------------------------------------
  // single accesses
  // ----------------------------------------------------------------
  // released lines show the inverse so a stale value never passes
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_wr_addr <= addr;
    o_wr_data <= data;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_wr_addr <= ~addr;
    o_wr_data <= ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data,
    output logic ok);
    int n;
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_rd_addr <= addr;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_rd_addr <= ~addr;
    n = 0;
    ok = 1'b0;
    data = 16'h0000;
    while (!ok && n < 4) begin
      #1;
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        data = i_rd_data;
      end else begin
        @(posedge i_clk);
        n++;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // cyclic image
  // ----------------------------------------------------------------
  // whole image rewritten in one pass
  task automatic write_image(input logic [15:0] base);
    for (int i = 0; i < 12; i++) begin
      write_reg(IMG[i], base + 16'(i));
    end
  endtask

endmodule

`default_nettype wire

// *** verif/zone_control_output_registers_bench.sv ***
/*
  Self-checking bench for the zone output register bank.
  Assumes the controller model owns the register port and the bench
  drives the zone-side inputs directly.
*/
`timescale 1ns/10ps
`default_nettype none

module zone_control_output_registers_bench;
  import zcor_pkg::*;

  localparam logic [7:0] OFFS [12] = '{OFF_LEFT_SPEED, OFF_RIGHT_SPEED,
    OFF_UP_ACCUM, OFF_UP_RELEASE, OFF_UP_HOLD1, OFF_UP_HOLD2, OFF_UP_INDUCT,
    OFF_DN_ACCUM, OFF_DN_RELEASE, OFF_DN_HOLD1, OFF_DN_HOLD2,
    OFF_DN_DISCHARGE};
  localparam logic [15:0] CTRL [10] = '{16'h0001, 16'h0100, 16'h0200,
    16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h0401, 16'hc0fe, 16'hffff};

  logic clk, reset, wr_en, rd_en, rd_valid, gear, unit_x10;
  logic induct_track, dn_hold, dn_rel_ok;
  logic [7:0] wr_addr, rd_addr;
  logic [15:0] wr_data, rd_data, cfg_left, cfg_right, left_ref, right_ref, v;
  logic [1:0] discharged, arrival, rel_pulse, accum, accum_up, confirm;
  logic [1:0] jog_f, jog_r, wake, maint, up_busy, flash, motor_en, jam;
  logic [1:0][15:0] live1, live2, echo;
  logic [15:0] exp1 [2];
  logic [15:0] exp2 [2];
  int bad_count, n_checks;

  always #2.5 clk = ~clk;

  zcor_output_regs #(.ARRIVAL_WAIT_CYCLES(4)) u_dut (
    .i_clk(clk), .i_reset(reset), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .i_configured_left_speed(cfg_left), .i_configured_right_speed(cfg_right),
    .i_gear_drive(gear), .i_zone_discharged(discharged),
    .i_arrival_seen(arrival), .o_release_pulse(rel_pulse),
    .o_accumulate(accum), .o_accum_upstream(accum_up),
    .o_arrival_confirm(confirm), .o_jog_fwd(jog_f), .o_jog_rev(jog_r),
    .o_wake(wake), .o_maintenance(maint), .o_upstream_busy(up_busy),
    .o_indicator_flash_green(flash), .o_motor_enable(motor_en), .o_jam(jam),
    .o_live_word1(live1), .o_live_word2(live2), .o_release_echo(echo),
    .o_left_speed_ref(left_ref), .o_right_speed_ref(right_ref),
    .o_speed_unit_rpm_x10(unit_x10), .o_induct_accept_tracking(induct_track),
    .o_downstream_hold(dn_hold), .o_downstream_release_ok(dn_rel_ok));

  zcor_plc_model u_plc (
    .i_clk(clk), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_rd_en(rd_en), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_plc.read_reg(addr, d, ok);
    check(16'(ok), 16'h0001, "read answer");
    check(d, exp, "read data");
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    discharged <= 2'b00;
    arrival <= 2'b00;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    exp1 = '{16'h0000, 16'h0000};
    exp2 = '{16'h0000, 16'h0000};
  endtask

  task automatic ctrl_case(input int z, input logic [15:0] c);
    logic [15:0] m;
    logic [7:0] a;
    m = c & ACCUM_USED_MASK;
    a = z == 1 ? OFF_DN_ACCUM : OFF_UP_ACCUM;
    u_plc.write_reg(a, c);
    #1;
    check(16'({accum[z], accum_up[z], confirm[z]}),
      16'({m[0] & ~m[10] & ~m[11], m[8], m[9]}), "accumulate");
    check(16'({jog_f[z], jog_r[z], wake[z]}),
      16'({m[10], m[11], m[12]}), "jog and wake");
    check(16'({maint[z], up_busy[z], flash[z], motor_en[z]}),
      16'({m[13], m[13], m[13], ~m[13]}), "maintenance");
    read_check(a, m);
  endtask

  task automatic rel_case(input int z, input logic [15:0] h1, h2, rv,
    input logic p);
    u_plc.write_reg(z == 1 ? OFF_DN_HOLD1 : OFF_UP_HOLD1, h1);
    u_plc.write_reg(z == 1 ? OFF_DN_HOLD2 : OFF_UP_HOLD2, h2);
    #1;
    check(live1[z], exp1[z], "live word before release");
    u_plc.write_reg(z == 1 ? OFF_DN_RELEASE : OFF_UP_RELEASE, rv);
    #1;
    check(16'(rel_pulse[z]), 16'(p), "release pulse");
    check(echo[z], rv, "release echo");
    @(posedge clk);
    #1;
    check(16'(rel_pulse[z]), 16'h0000, "pulse width");
    if (p && (h1 | h2) != 16'h0000) begin
      exp1[z] = (h1 & h2) == 16'hffff ? 16'h0000 : h1;
      exp2[z] = (h1 & h2) == 16'hffff ? 16'h0000 : h2;
    end
    check(live1[z], exp1[z], "live word 1");
    check(live2[z], exp2[z], "live word 2");
  endtask

  task automatic spd_case(input int s, input logic [15:0] w, e);
    u_plc.write_reg(s == 1 ? OFF_RIGHT_SPEED : OFF_LEFT_SPEED, w);
    #1;
    check(s == 1 ? right_ref : left_ref, e, "speed reference");
  endtask

  task automatic stat_case(input logic [7:0] a, input logic [15:0] w, e);
    u_plc.write_reg(a, w);
    #1;
    check(16'({wake[0], induct_track, dn_hold, accum[1], dn_rel_ok}), e,
      "status outputs");
  endtask

  task automatic disc_pulse();
    @(posedge clk);
    discharged <= 2'b01;
    @(posedge clk);
    discharged <= 2'b00;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    gear = 1'b0;
    discharged = 2'b00;
    arrival = 2'b00;
    cfg_left = 16'h0064;
    cfg_right = 16'h00c8;
    do_reset();
    for (int i = 0; i < 12; i++) read_check(OFFS[i], 16'h0000);
    check(16'(motor_en), 16'h0003, "motor enable");
    check(16'(unit_x10), 16'h0000, "speed unit");
    u_plc.write_image(16'hff00);
    u_plc.write_reg(8'h00, 16'h5a5a);
    read_check(8'h00, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      v = 16'hff00 + 16'(i);
      if (i == 2 || i == 7) v = v & ACCUM_USED_MASK;
      read_check(OFFS[i], v);
    end
    do_reset();
    for (int z = 0; z < 2; z++) begin
      foreach (CTRL[k]) ctrl_case(z, CTRL[k]);
    end
    do_reset();
    for (int z = 0; z < 2; z++) begin
      u_plc.write_reg(z == 1 ? OFF_DN_ACCUM : OFF_UP_ACCUM, 16'h0001);
      rel_case(z, 16'h1234, 16'h5678, 16'h0001, 1'b1);
      rel_case(z, 16'h0000, 16'h0000, 16'h0002, 1'b1);
      rel_case(z, 16'hffff, 16'hffff, 16'h0003, 1'b1);
      rel_case(z, 16'hffff, 16'h00aa, 16'h0004, 1'b1);
      rel_case(z, 16'h00bb, 16'hffff, 16'h0005, 1'b1);
      u_plc.write_reg(z == 1 ? OFF_DN_ACCUM : OFF_UP_ACCUM, 16'h0000);
      rel_case(z, 16'h1111, 16'h2222, 16'h0006, 1'b0);
    end
    do_reset();
    for (int s = 0; s < 2; s++) begin
      spd_case(s, 16'h0000, s == 1 ? cfg_right : cfg_left);
      spd_case(s, 16'h0190, 16'h0190);
      spd_case(s, 16'h0000, 16'h0190);
    end
    @(posedge clk);
    gear <= 1'b1;
    @(posedge clk);
    #1;
    check(16'(unit_x10), 16'h0001, "speed unit");
    stat_case(OFF_UP_INDUCT, 16'h0004, 16'h0010);
    stat_case(OFF_UP_INDUCT, 16'h0001, 16'h0008);
    stat_case(OFF_DN_DISCHARGE, 16'h0005, 16'h000e);
    stat_case(OFF_DN_DISCHARGE, 16'h0001, 16'h0009);
    do_reset();
    disc_pulse();
    check(16'(jam), 16'h0001, "jam without arrival");
    @(posedge clk);
    arrival <= 2'b01;
    @(posedge clk);
    arrival <= 2'b00;
    repeat (2) @(posedge clk);
    #1;
    check(16'(jam), 16'h0000, "jam after arrival");
    u_plc.write_reg(OFF_UP_ACCUM, 16'h0200);
    disc_pulse();
    check(16'(jam), 16'h0000, "jam with confirm bit");
    complete_run();
  end

endmodule

`default_nettype wire
